/* File: core/fps_ctrl.sv */
// Fan static pressure selection and auto-restart control with APB registers
//
// Contract
// R1 - Override zero: switches 2,1 decode OFF/OFF 10, OFF/ON 20, ON/OFF 35, ON/ON 45 Pa.
// R2 - Override values 1, 2, 3, 4 select 10, 20, 35, 45 Pa.
// R3 - Any non-zero override value makes the switch positions irrelevant.
// R4 - Reset leaves override zero; switches off then give the lowest level.
// R5 - Auto-restart on: resume previous run state three minutes after power returns.
// R6 - Auto-restart flag is clear after reset.
// R7 - A button hold of at least three seconds toggles auto-restart.
// R8 - The hold must end before ten seconds, otherwise no toggle.
// R9 - Enabling sounds three beeps and blinks the lamp 5/s for 5 s.
// R10 - Press in standby starts the unit at once, lamp on; long hold beeps.
// R11 - Press while running stops the unit at once, lamp off; long hold beeps.
// R12 - A later short press toggles run state like a remote on/off command.
// R13 - Long press while enabled clears the flag with three beeps.
// R14 - Auto-restart off: unit stays stopped after power returns until commanded.
// R15 - A timer active at power loss is discarded on recovery.
// R16 - Disabling sounds three beeps without lamp blinking.
// R17 - Button start selects auto mode, 24 C setpoint and auto fan.
// R18 - Flag and operating conditions survive mains loss, cleared only by reset.
`timescale 1ns/10ps
module fps_ctrl #(
  parameter logic [31:0] LONG_PRESS_CYC = 32'(fps_pkg::LONG_PRESS_CYC),
  parameter logic [31:0] PRESS_LIMIT_CYC = 32'(fps_pkg::PRESS_LIMIT_CYC),
  parameter logic [31:0] RESTART_DELAY_CYC = 32'(fps_pkg::RESTART_DELAY_CYC),
  parameter logic [31:0] BLINK_HALF_CYC = 32'(fps_pkg::BLINK_HALF_CYC),
  parameter logic [31:0] BEEP_HALF_CYC = 32'(fps_pkg::BEEP_HALF_CYC)
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Board pins
  input wire logic [1:0] pressure_select_switches_in,
  input wire logic temp_button_n_in,
  input wire logic mains_ok_in,
  // Unit outputs
  output logic [1:0] pressure_level_out,
  output logic run_out,
  output logic lamp_out,
  output logic beep_out,
  output logic auto_restart_out,
  output logic timer_active_out,
  output logic [1:0] mode_out,
  output logic [2:0] fan_out,
  output logic [4:0] setpoint_out
);
  typedef enum {FPS_PWR_DOWN, FPS_PWR_WAIT, FPS_PWR_UP} fps_pwr_t;

  typedef struct packed {
    fps_pwr_t pwr;
    logic [31:0] wait_cnt;
    logic [31:0] hold_cnt;
    logic btn_prev;
    logic run;
    logic last_run;
    logic auto_en;
    logic timer_active;
    logic [15:0] override_item;
    logic [1:0] mode;
    logic [2:0] fan;
    logic [4:0] setpoint;
    logic [1:0] level;
    logic lamp;
    logic beep;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } fps_ctrl_state_t;

  fps_ctrl_state_t state;
  fps_ctrl_state_t next_state;

  logic [3:0] pin_sync;
  logic btn_pressed;
  logic mains_ok;
  logic [1:0] sw_sync;
  logic beep_start;
  logic blink_start;
  logic blink_abort;
  logic beep_active;
  logic beep_wave;
  logic blink_active;
  logic blink_wave;
  logic apb_setup;
  logic apb_write;

  // Static pressure level from override item and switches
  function automatic logic [1:0] fps_level(input logic [15:0] item, input logic [1:0] sw);
    logic [1:0] lvl;
    lvl = fps_pkg::LEVEL_10PA;
    case (item)
      16'h0000: lvl = sw;                      // [R1] [R4]
      16'h0001: lvl = fps_pkg::LEVEL_10PA;     // [R2] [R3]
      16'h0002: lvl = fps_pkg::LEVEL_20PA;     // [R2] [R3]
      16'h0003: lvl = fps_pkg::LEVEL_35PA;     // [R2] [R3]
      16'h0004: lvl = fps_pkg::LEVEL_45PA;     // [R2] [R3]
      default: lvl = fps_pkg::LEVEL_10PA;      // [R3]
    endcase
    return lvl;
  endfunction

  fps_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in({pressure_select_switches_in, mains_ok_in, ~temp_button_n_in}),
    .sync_out(pin_sync)
  );

  assign sw_sync = pin_sync[3:2];
  assign mains_ok = pin_sync[1];
  assign btn_pressed = pin_sync[0];

  fps_pulser #(
    .HALF_CYC(BEEP_HALF_CYC),
    .PULSES(8'(fps_pkg::BEEP_COUNT))
  ) u_beep (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .start_in(beep_start),
    .abort_in(1'b0),
    .active_out(beep_active),
    .wave_out(beep_wave)
  );

  fps_pulser #(
    .HALF_CYC(BLINK_HALF_CYC),
    .PULSES(8'(fps_pkg::BLINK_COUNT))
  ) u_blink (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .start_in(blink_start),
    .abort_in(blink_abort),
    .active_out(blink_active),
    .wave_out(blink_wave)
  );

  assign apb_setup = psel_in && !penable_in;
  assign apb_write = psel_in && penable_in && pwrite_in && state.ready;

  always_comb
  begin
    logic long_ok;
    logic run_cmd_on;
    logic run_cmd_off;
    long_ok = 1'b0;
    run_cmd_on = 1'b0;
    run_cmd_off = 1'b0;
    next_state = state;
    beep_start = 1'b0;
    blink_start = 1'b0;
    blink_abort = 1'b0;
    next_state.btn_prev = btn_pressed;

    // APB register writes
    if (apb_write)
    begin
      case (paddr_in)
        fps_pkg::OFS_OVERRIDE:
          next_state.override_item = pwdata_in[15:0];
        fps_pkg::OFS_CONDITIONS:
        begin
          next_state.mode = pwdata_in[fps_pkg::COND_MODE_LSB +: 2];
          next_state.fan = pwdata_in[fps_pkg::COND_FAN_LSB +: 3];
          next_state.setpoint = pwdata_in[fps_pkg::COND_TEMP_LSB +: 5];
        end
        fps_pkg::OFS_COMMAND:
        begin
          run_cmd_on = pwdata_in[fps_pkg::CMD_RUN_ON];
          run_cmd_off = pwdata_in[fps_pkg::CMD_RUN_OFF];
          if (pwdata_in[fps_pkg::CMD_TIMER_CLR])
            next_state.timer_active = 1'b0;
          if (pwdata_in[fps_pkg::CMD_TIMER_SET] && state.pwr == FPS_PWR_UP)
            next_state.timer_active = 1'b1;
        end
        default:
          next_state.override_item = state.override_item;
      endcase
    end

    // Power sequencing
    case (state.pwr)
      FPS_PWR_DOWN:
      begin
        next_state.run = 1'b0;
        next_state.timer_active = 1'b0;                 // [R15]
        next_state.wait_cnt = '0;
        if (mains_ok)
        begin
          if (state.auto_en)
            next_state.pwr = FPS_PWR_WAIT;              // [R5]
          else
            next_state.pwr = FPS_PWR_UP;                // [R14]
        end
      end
      FPS_PWR_WAIT:
      begin
        if (!mains_ok)
          next_state.pwr = FPS_PWR_DOWN;
        else if (state.wait_cnt >= RESTART_DELAY_CYC - 32'h0000_0001)
        begin
          next_state.pwr = FPS_PWR_UP;
          next_state.run = state.last_run;              // [R5] [R18]
        end
        else
          next_state.wait_cnt = state.wait_cnt + 32'h0000_0001;
      end
      FPS_PWR_UP:
      begin
        if (!mains_ok)
        begin
          next_state.pwr = FPS_PWR_DOWN;
          next_state.last_run = state.run;              // [R18]
          next_state.run = 1'b0;
          next_state.timer_active = 1'b0;               // [R15]
          blink_abort = 1'b1;
        end
        else
        begin
          if (run_cmd_on)
            next_state.run = 1'b1;                      // [R14]
          else if (run_cmd_off)
            next_state.run = 1'b0;

          // Button press edge switches run state at once
          if (btn_pressed && !state.btn_prev)
          begin
            next_state.run = ~state.run;                // [R10] [R11] [R12]
            if (!state.run)
            begin
              next_state.mode = fps_pkg::MODE_AUTO;     // [R17]
              next_state.setpoint = fps_pkg::TEMP_BUTTON_SETPOINT; // [R17]
              next_state.fan = fps_pkg::FAN_AUTO;       // [R17]
            end
          end

          // Release after a long hold toggles the auto-restart flag
          long_ok = state.hold_cnt >= LONG_PRESS_CYC && state.hold_cnt < PRESS_LIMIT_CYC;
          if (!btn_pressed && state.btn_prev && long_ok)    // [R7] [R8]
          begin
            next_state.auto_en = ~state.auto_en;        // [R7] [R13]
            beep_start = 1'b1;                          // [R9] [R13] [R16]
            blink_start = !state.auto_en;               // [R9] [R16]
            blink_abort = state.auto_en;                // [R16]
          end
        end
      end
      default:
        next_state.pwr = FPS_PWR_DOWN;
    endcase

    // Hold time, saturating at the release limit
    if (!btn_pressed)
      next_state.hold_cnt = '0;
    else if (state.hold_cnt < PRESS_LIMIT_CYC)
      next_state.hold_cnt = state.hold_cnt + 32'h0000_0001;  // [R8]

    // Registered unit outputs
    next_state.level = fps_level(state.override_item, sw_sync);
    next_state.lamp = blink_active ? blink_wave : state.run;  // [R9] [R10] [R11]
    next_state.beep = beep_active && beep_wave;               // [R9]

    // APB read data is captured in the setup cycle, answered in the access cycle
    next_state.ready = apb_setup;
    next_state.slverr = 1'b0;
    next_state.rdata = '0;
    if (apb_setup)
    begin
      case (paddr_in)
        fps_pkg::OFS_OVERRIDE:
          next_state.rdata[15:0] = state.override_item;
        fps_pkg::OFS_CONDITIONS:
        begin
          next_state.rdata[fps_pkg::COND_MODE_LSB +: 2] = state.mode;
          next_state.rdata[fps_pkg::COND_FAN_LSB +: 3] = state.fan;
          next_state.rdata[fps_pkg::COND_TEMP_LSB +: 5] = state.setpoint;
        end
        fps_pkg::OFS_COMMAND:
          next_state.rdata = '0;
        fps_pkg::OFS_STATUS:
        begin
          next_state.rdata[fps_pkg::ST_LEVEL_LSB +: 2] = state.level;
          next_state.rdata[fps_pkg::ST_RUN] = state.run;
          next_state.rdata[fps_pkg::ST_AUTO_EN] = state.auto_en;
          next_state.rdata[fps_pkg::ST_TIMER] = state.timer_active;
          next_state.rdata[fps_pkg::ST_WAITING] = state.pwr == FPS_PWR_WAIT;
          next_state.rdata[fps_pkg::ST_MAINS] = mains_ok;
          next_state.rdata[fps_pkg::ST_BEEPING] = beep_active;
          next_state.rdata[fps_pkg::ST_BLINKING] = blink_active;
          next_state.rdata[fps_pkg::ST_SW_LSB +: 2] = sw_sync;
        end
        default:
          next_state.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= '0;
      state.pwr <= FPS_PWR_DOWN;
      state.auto_en <= 1'b0;                                  // [R6]
      state.override_item <= fps_pkg::OVERRIDE_RST;           // [R4]
      state.mode <= fps_pkg::MODE_AUTO;
      state.fan <= fps_pkg::FAN_AUTO;
      state.setpoint <= fps_pkg::TEMP_BUTTON_SETPOINT;
      state.level <= fps_pkg::LEVEL_10PA;
    end
    else
      state <= next_state;
  end

  assign prdata_out = state.rdata;
  assign pready_out = state.ready;
  assign pslverr_out = state.slverr;
  assign pressure_level_out = state.level;
  assign run_out = state.run;
  assign lamp_out = state.lamp;
  assign beep_out = state.beep;
  assign auto_restart_out = state.auto_en;
  assign timer_active_out = state.timer_active;
  assign mode_out = state.mode;
  assign fan_out = state.fan;
  assign setpoint_out = state.setpoint;
endmodule // fps_ctrl

/* File: core/fps_pkg.sv */
// Constants, register map and time figures for the fan pressure and auto-restart block
package fps_pkg;
  // Clock rate
  localparam int unsigned CLK_KHZ = 20000;

  // Time figures in their own units
  localparam int unsigned LONG_PRESS_MS = 3000;
  localparam int unsigned PRESS_LIMIT_MS = 10000;
  localparam int unsigned RESTART_DELAY_S = 180;
  localparam int unsigned BLINK_TIME_MS = 5000;
  localparam int unsigned BLINK_RATE_HZ = 5;
  localparam int unsigned BEEP_HALF_MS = 100;
  localparam int unsigned BEEP_COUNT = 3;

  // Cycle counts derived from the rate
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
  localparam int unsigned PRESS_LIMIT_CYC = PRESS_LIMIT_MS * CLK_KHZ;
  localparam int unsigned RESTART_DELAY_CYC = RESTART_DELAY_S * 1000 * CLK_KHZ;
  localparam int unsigned BLINK_HALF_CYC = (CLK_KHZ * 1000) / (2 * BLINK_RATE_HZ);
  localparam int unsigned BLINK_COUNT = (BLINK_TIME_MS * BLINK_RATE_HZ) / 1000;
  localparam int unsigned BEEP_HALF_CYC = BEEP_HALF_MS * CLK_KHZ;
  localparam int unsigned CNT_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_OVERRIDE = 8'h00;
  localparam logic [7:0] OFS_CONDITIONS = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // Command bits
  localparam int CMD_RUN_ON = 0;
  localparam int CMD_RUN_OFF = 1;
  localparam int CMD_TIMER_SET = 2;
  localparam int CMD_TIMER_CLR = 3;

  // Condition field layout
  localparam int COND_MODE_LSB = 0;
  localparam int COND_FAN_LSB = 4;
  localparam int COND_TEMP_LSB = 8;

  // Status bit layout
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_RUN = 2;
  localparam int ST_AUTO_EN = 3;
  localparam int ST_TIMER = 4;
  localparam int ST_WAITING = 5;
  localparam int ST_MAINS = 6;
  localparam int ST_BEEPING = 7;
  localparam int ST_BLINKING = 8;
  localparam int ST_SW_LSB = 9;

  // Reset values and encodings
  localparam logic [15:0] OVERRIDE_RST = 16'h0000;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [2:0] FAN_AUTO = 3'h0;
  localparam logic [4:0] TEMP_BUTTON_SETPOINT = 5'h18;
  localparam logic [1:0] LEVEL_10PA = 2'h0;
  localparam logic [1:0] LEVEL_20PA = 2'h1;
  localparam logic [1:0] LEVEL_35PA = 2'h2;
  localparam logic [1:0] LEVEL_45PA = 2'h3;
endpackage

/* File: core/fps_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module fps_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } fps_sync_state_t;

  fps_sync_state_t state;
  fps_sync_state_t next_state;

  always_comb
  begin
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.stage2;
endmodule // fps_sync

/* File: core/fps_pulser.sv */
// Burst generator: a fixed number of on/off pulses after a start strobe
`timescale 1ns/10ps
module fps_pulser #(
  parameter logic [31:0] HALF_CYC = 32'h0000_0001,
  parameter logic [7:0] PULSES = 8'h03
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Control
  input wire logic start_in,
  input wire logic abort_in,
  // Outputs
  output logic active_out,
  output logic wave_out
);
  typedef struct packed {
    logic active;
    logic wave;
    logic [31:0] cnt;
    logic [7:0] done;
  } fps_pulser_state_t;

  fps_pulser_state_t state;
  fps_pulser_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (start_in)
    begin
      next_state.active = 1'b1;
      next_state.wave = 1'b1;
      next_state.cnt = '0;
      next_state.done = '0;
    end
    else if (abort_in)
    begin
      next_state.active = 1'b0;
      next_state.wave = 1'b0;
    end
    else if (state.active)
    begin
      if (state.cnt >= HALF_CYC - 32'h0000_0001)
      begin
        next_state.cnt = '0;
        next_state.wave = ~state.wave;
        if (state.wave)
        begin
          next_state.done = state.done + 8'h01;
          if (state.done + 8'h01 >= PULSES)
            next_state.active = 1'b0;
        end
      end
      else
        next_state.cnt = state.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state <= '0;
    else
      state <= next_state;
  end

  assign active_out = state.active;
  assign wave_out = state.wave;
endmodule // fps_pulser

/* File: core/fps_unused_guard.sv */
// Intentionally empty: no logic of the block lives here

/* File: test/fps_ctrl_properties.sv */
// Port-level assertions for the fan pressure and auto-restart controller
`timescale 1ns/10ps
module fps_ctrl_properties #(
  parameter logic [31:0] BEEP_HALF_CYC = 32'h0000_0003
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pins and unit outputs
  input wire logic temp_button_n_in,
  input wire logic mains_ok_in,
  input wire logic run_out,
  input wire logic beep_out,
  input wire logic auto_restart_out
);
  logic [31:0] beep_len;
  logic mapped;
  assign mapped = paddr_in inside {fps_pkg::OFS_OVERRIDE, fps_pkg::OFS_CONDITIONS,
    fps_pkg::OFS_COMMAND, fps_pkg::OFS_STATUS};
  // Length of the current beep
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      beep_len <= 32'h0;
    else
      beep_len <= beep_out ? beep_len + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready_out |-> psel_in && penable_in ##1 !pready_out)
    else $error("pready outside one access cycle");
  a_err_unmapped: assert property (pready_out && !mapped |-> pslverr_out)
    else $error("no error on unmapped address");
  a_err_only_unmapped: assert property (pslverr_out |-> pready_out && !mapped)
    else $error("error on mapped address");
  a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside access");
  a_flag_on_release: assert property ($changed(auto_restart_out) |-> $past(temp_button_n_in))
    else $error("flag changed while button held");
  a_toggle_beeps: assert property ($changed(auto_restart_out) |-> ##[0:4] beep_out)
    else $error("no beep after flag toggle");
  a_beep_width: assert property ($fell(beep_out) |-> beep_len == BEEP_HALF_CYC)
    else $error("beep length wrong");
  a_run_mains_down: assert property (!mains_ok_in [*4] |-> !run_out)
    else $error("running without mains");
endmodule // fps_ctrl_properties

bind fps_ctrl fps_ctrl_properties #(.BEEP_HALF_CYC(BEEP_HALF_CYC)) u_props (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .temp_button_n_in(temp_button_n_in),
  .mains_ok_in(mains_ok_in), .run_out(run_out), .beep_out(beep_out),
  .auto_restart_out(auto_restart_out));

/* File: test/fps_operator.sv */
// Operator model pressing the local temporary button
`timescale 1ns/10ps
module fps_operator (
  // Clock
  input wire logic mclk_in,
  // Button pin, high when released
  output logic temp_button_n_out
);
  initial temp_button_n_out = 1'b1;
  // Hold the button for a number of cycles, then let go
  task automatic press(input int hold);
    @(posedge mclk_in);
    temp_button_n_out <= 1'b0;
    repeat (hold) @(posedge mclk_in);
    temp_button_n_out <= 1'b1;
  endtask
endmodule // fps_operator

/* File: test/fps_ctrl_tb_top.sv */
// Self-checking testbench for the fan pressure and auto-restart controller
`timescale 1ns/10ps
module fps_ctrl_tb_top;
  logic mclk_in;
  logic nrst_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [1:0] sw;
  logic mains_ok_in;
  logic btn_n;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, run_out, lamp_out, beep_out, auto_restart_out;
  logic timer_active_out;
  logic [1:0] pressure_level_out, mode_out;
  logic [2:0] fan_out;
  logic [4:0] setpoint_out;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int nb, nl;
  logic [31:0] seed = 32'h0858D175;
  logic [31:0] rd, r32;
  logic er;
  logic [15:0] ov;

  fps_ctrl #(.LONG_PRESS_CYC(32'h0000_001E), .PRESS_LIMIT_CYC(32'h0000_0064),
    .RESTART_DELAY_CYC(32'h0000_0032), .BLINK_HALF_CYC(32'h0000_0004),
    .BEEP_HALF_CYC(32'h0000_0003)) dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pressure_select_switches_in(sw), .temp_button_n_in(btn_n), .mains_ok_in(mains_ok_in),
    .pressure_level_out(pressure_level_out), .run_out(run_out), .lamp_out(lamp_out),
    .beep_out(beep_out), .auto_restart_out(auto_restart_out),
    .timer_active_out(timer_active_out), .mode_out(mode_out), .fan_out(fan_out),
    .setpoint_out(setpoint_out));
  fps_operator op (.mclk_in(mclk_in), .temp_button_n_out(btn_n));

  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [1:0] lvl_of(input logic [15:0] o, input logic [1:0] s);
    logic [1:0] t [4];
    t = '{fps_pkg::LEVEL_10PA, fps_pkg::LEVEL_20PA, fps_pkg::LEVEL_35PA, fps_pkg::LEVEL_45PA};
    if (o == 16'h0000)
      return t[s];
    return (o <= 16'h0004) ? t[o[1:0] - 2'h1] : fps_pkg::LEVEL_10PA;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do
    begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    tick(1);
  endtask

  task watch(input int n);
    logic pb, pl;
    nb = 0;
    nl = 0;
    pb = beep_out;
    pl = lamp_out;
    repeat (n)
    begin
      @(negedge mclk_in);
      if (beep_out === 1'b1 && pb !== 1'b1) nb++;
      if (lamp_out === 1'b1 && pl !== 1'b1) nl++;
      pb = beep_out;
      pl = lamp_out;
    end
  endtask

  task long_press(input logic exp_flag, input int exp_blinks);
    op.press(40);
    watch(260);
    chk(auto_restart_out, exp_flag, "flag");
    chk(nb, 3, "beeps");
    chk(nl, exp_blinks, "blinks");
  endtask

  task summarize();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    nrst_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    sw = 2'h0;
    mains_ok_in = 1'b0;
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    tick(2);
    chk(auto_restart_out, 1'b0, "flag reset");
    chk(pressure_level_out, fps_pkg::LEVEL_10PA, "level reset");
    apb(1'b0, fps_pkg::OFS_OVERRIDE, 32'h0);
    chk(rd, 32'h0, "override reset");
    @(posedge mclk_in);
    mains_ok_in <= 1'b1;
    tick(5);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_in);
      sw <= i[1:0];
      tick(5);
      chk(pressure_level_out, lvl_of(16'h0, i[1:0]), "switch level");
    end
    for (int i = 1; i < 10; i++)
    begin
      r32 = xs();
      ov = (i < 5) ? i[15:0] : r32[15:0];
      apb(1'b1, fps_pkg::OFS_OVERRIDE, {16'h0, ov});
      @(posedge mclk_in);
      sw <= r32[17:16];
      tick(5);
      chk(pressure_level_out, lvl_of(ov, sw), "override level");
    end
    apb(1'b1, fps_pkg::OFS_OVERRIDE, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    $display("test pressure done");
    apb(1'b1, fps_pkg::OFS_CONDITIONS, 32'h0000_1432);
    op.press(5);
    tick(6);
    chk(run_out, 1'b1, "button start");
    chk({mode_out, fan_out, setpoint_out}, {fps_pkg::MODE_AUTO, fps_pkg::FAN_AUTO,
      fps_pkg::TEMP_BUTTON_SETPOINT}, "button conditions");
    long_press(1'b1, 25);
    chk(run_out, 1'b0, "stop on press");
    apb(1'b0, fps_pkg::OFS_STATUS, 32'h0);
    chk(rd[fps_pkg::ST_AUTO_EN], 1'b1, "status flag");
    op.press(5);
    tick(6);
    chk(run_out, 1'b1, "short press");
    $display("test button done");
    apb(1'b1, fps_pkg::OFS_COMMAND, 32'h0000_0004);
    tick(2);
    chk(timer_active_out, 1'b1, "timer set");
    @(posedge mclk_in);
    mains_ok_in <= 1'b0;
    tick(10);
    chk({run_out, timer_active_out, auto_restart_out}, 3'h1, "power loss");
    @(posedge mclk_in);
    mains_ok_in <= 1'b1;
    tick(40);
    chk(run_out, 1'b0, "restart wait");
    tick(20);
    chk({run_out, timer_active_out}, 2'h2, "restarted");
    $display("test restart done");
    long_press(1'b0, 0);
    chk(run_out, 1'b0, "stop on cancel");
    op.press(120);
    watch(60);
    chk({auto_restart_out, run_out, nb[1:0]}, 4'h4, "overlong hold");
    @(posedge mclk_in);
    mains_ok_in <= 1'b0;
    tick(10);
    @(posedge mclk_in);
    mains_ok_in <= 1'b1;
    tick(100);
    chk(run_out, 1'b0, "stays stopped");
    apb(1'b1, fps_pkg::OFS_COMMAND, 32'h0000_0001);
    tick(3);
    chk(run_out, 1'b1, "remote start");
    $display("test power done");
    summarize();
  end
endmodule // fps_ctrl_tb_top
